/* File: src/bfs_supervisor.sv */
// Fault supervisor and operating sequencer of a backlight boost driver.
// Assumes analog indications arrive asynchronously and an AHB-Lite master.
//
// The register addresses and the AHB-Lite register port were decided locally.
module bfs_supervisor #(
  parameter int BOOST_UV_CYC = bfs_pkg::BOOST_UV_CYC,
  parameter int RECOVERY_CYC = bfs_pkg::RECOVERY_CYC,
  parameter int DISCHARGE_CYC = bfs_pkg::DISCHARGE_CYC,
  parameter int SHORT_CYC = bfs_pkg::SHORT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog front end
  input wire bfs_pkg::bfs_sense_t sense_i,
  output bfs_pkg::bfs_drive_t drive_o,
  // Host alert
  output logic host_alert_n
);
  localparam int TW = bfs_pkg::TMR_W;

  bfs_pkg::bfs_regs_t r, n;

  assign hreadyout = r.hready;
  assign hresp = r.hresp;
  assign hrdata = r.rdata;
  assign drive_o = r.drive;
  assign host_alert_n = r.alert_n;

  // ==========================================================
  // Next-state logic
  always_comb begin
    bfs_pkg::bfs_sense_t s;
    logic [14:0] set, clr;
    logic [5:0] act, shorted, opened;
    logic mon_vin, running, hold, any;
    s = r.sync;
    set = '0;
    clr = '0;
    shorted = '0;
    opened = '0;
    mon_vin = 1'b0;
    running = 1'b0;
    hold = 1'b0;
    any = 1'b0;
    n = r;
    // Two-stage synchroniser; only stage two is looked at
    n.meta = sense_i;
    n.sync = r.meta;
    act = ~r.str_dis;
    // clear needs status and clear bit together
    if (r.ap_wr && r.ap_addr == bfs_pkg::OFS_STATUS) begin
      clr = hwdata[14:0] & hwdata[bfs_pkg::CLR_POS +: 15] & bfs_pkg::CLEARABLE;
    end
    // pairs of 01 disable, 11 enable, others keep
    if (r.ap_wr && r.ap_addr == bfs_pkg::OFS_INT_EN) begin
      for (int i = 0; i < bfs_pkg::NFLAG; i++) begin
        if (hwdata[2*i +: 2] == 2'h3) begin
          n.int_en[i] = 1'b1;
        end else if (hwdata[2*i +: 2] == 2'h1) begin
          n.int_en[i] = 1'b0;
        end
      end
      n.glob_en = hwdata[bfs_pkg::GLOB_POS];
    end
    if (r.ap_wr && r.ap_addr == bfs_pkg::OFS_CONTROL) begin
      n.enable = hwdata[0];
      n.bright = hwdata[1];
    end
    if (r.ap_wr && r.ap_addr == bfs_pkg::OFS_CONFIG && r.state == bfs_pkg::ST_STANDBY) begin
      n.cfg_thr = hwdata[1:0];
    end
    // ----------------------------------------------------------
    // Sequencer
    case (r.state)
      // wait for regulator, trims and detection
      bfs_pkg::ST_INIT: begin
        if (s.init_done) begin
          n.state = bfs_pkg::ST_STANDBY;
          if (!s.config_valid) begin
            set[bfs_pkg::F_BAD_CFG] = 1'b1;
            n.six_phase = 1'b1;
          end
          // resistor fault locks the boost off
          if (s.boost_freq_resistor_bad || s.dimming_freq_resistor_bad) begin
            set[bfs_pkg::F_FREQ_RES] = 1'b1;
            n.fset_lock = 1'b1;
          end
        end
      end
      bfs_pkg::ST_STANDBY: begin
        // no restart while output stays above high OVP
        hold = s.vin_over || s.vin_under || s.vdd_under || s.temp_over ||
               s.fb_over_ovph || r.fset_lock;
        if (r.enable && !hold) begin
          n.state = bfs_pkg::ST_PLSOFT;
          n.sync_seen = s.sync_valid;
        end
      end
      // FET on until capacitors reach input level
      bfs_pkg::ST_PLSOFT: begin
        if (s.pl_charged) begin
          n.state = bfs_pkg::ST_BOOSTUP;
        end
      end
      bfs_pkg::ST_BOOSTUP: begin
        if (s.fb_target_reached) begin
          n.state = bfs_pkg::ST_NORMAL;
        end
      end
      bfs_pkg::ST_NORMAL: begin
        // flag on each new excursion, no state change
        if (s.fb_over_ovpl && !r.drive.boost_switch_halt) begin
          set[bfs_pkg::F_OVP_LOW] = 1'b1;
        end
        if (s.fb_over_ovph) begin
          set[bfs_pkg::F_OVP_HIGH] = 1'b1;
          n.state = bfs_pkg::ST_RECOVERY;
        end else if (!r.enable) begin
          n.state = bfs_pkg::ST_DISCHARGE;
        end
        // still low with boost at its ceiling
        opened = s.string_low & act & {6{s.boost_at_max}};
        if (|opened) begin
          n.str_dis = n.str_dis | opened;
          n.open_str = r.open_str | opened;
          set[bfs_pkg::F_STRING] = 1'b1;
          set[bfs_pkg::F_OPEN] = 1'b1;
        end
        // one shared timer; all shorted strings drop together
        shorted = s.string_short & act;
        if ((|shorted) && (|(act & ~s.string_short))) begin
          n.short_cnt = r.short_cnt + TW'(1);
          if (r.short_cnt == TW'(SHORT_CYC - 1)) begin
            n.str_dis = n.str_dis | shorted;
            set[bfs_pkg::F_STRING] = 1'b1;
            n.short_cnt = '0;
          end
        end else begin
          n.short_cnt = '0;
        end
      end
      bfs_pkg::ST_DISCHARGE: begin
        if (s.fb_below_discharge || r.timer == TW'(DISCHARGE_CYC - 1)) begin
          n.state = bfs_pkg::ST_STANDBY;
        end
      end
      // hold off, then standby decides on enable
      bfs_pkg::ST_RECOVERY: begin
        if (r.timer == TW'(RECOVERY_CYC - 1)) begin
          n.state = bfs_pkg::ST_STANDBY;
        end
      end
      bfs_pkg::ST_LATCH: begin
        n.state = bfs_pkg::ST_LATCH;
      end
      default: begin
        n.state = bfs_pkg::ST_INIT;
      end
    endcase
    // ----------------------------------------------------------
    // Fault overrides, lowest priority first
    running = r.state inside {bfs_pkg::ST_PLSOFT, bfs_pkg::ST_BOOSTUP,
                              bfs_pkg::ST_NORMAL, bfs_pkg::ST_DISCHARGE};
    mon_vin = running;
    if (r.state inside {bfs_pkg::ST_PLSOFT, bfs_pkg::ST_BOOSTUP} && !r.enable) begin
      n.state = bfs_pkg::ST_STANDBY;
    end
    // persistent undervoltage counted from boost start
    if (r.state inside {bfs_pkg::ST_BOOSTUP, bfs_pkg::ST_NORMAL} && s.fb_under_uvp) begin
      n.uvp_cnt = r.uvp_cnt + TW'(1);
      if (r.uvp_cnt == TW'(BOOST_UV_CYC - 1)) begin
        set[bfs_pkg::F_BOOST_OC] = 1'b1;
        n.state = bfs_pkg::ST_RECOVERY;
      end
    end else begin
      n.uvp_cnt = '0;
    end
    if (mon_vin && s.vin_overcurrent) begin
      set[bfs_pkg::F_VIN_OC] = 1'b1;
      n.state = bfs_pkg::ST_RECOVERY;
    end
    // clock present at enable then lost
    if (r.state inside {bfs_pkg::ST_BOOSTUP, bfs_pkg::ST_NORMAL} &&
        r.sync_seen && !s.sync_valid) begin
      set[bfs_pkg::F_SYNC_LOST] = 1'b1;
      n.sync_seen = 1'b0;
      n.fallback = 1'b1;
    end
    if (mon_vin && s.vin_over) begin
      set[bfs_pkg::F_VIN_OV] = 1'b1;
      n.state = bfs_pkg::ST_STANDBY;
    end
    if (mon_vin && s.vin_under) begin
      set[bfs_pkg::F_VIN_UV] = 1'b1;
      n.state = bfs_pkg::ST_STANDBY;
    end
    // core supply low, watched after init
    if (r.state != bfs_pkg::ST_INIT && s.vdd_under) begin
      set[bfs_pkg::F_CORE_LOW] = 1'b1;
      if (running) begin
        n.state = bfs_pkg::ST_STANDBY;
      end
    end
    if (r.state != bfs_pkg::ST_INIT && s.temp_over) begin
      set[bfs_pkg::F_OVERTEMP] = 1'b1;
      if (running) begin
        n.state = bfs_pkg::ST_STANDBY;
      end
    end
    if (r.state != bfs_pkg::ST_INIT) begin
      set[bfs_pkg::F_PUMP_LVL] = s.pump_level_bad;
      set[bfs_pkg::F_PUMP_PARTS] = s.pump_parts_missing;
    end
    if (&n.str_dis) begin
      n.state = bfs_pkg::ST_LATCH;
    end
    n.timer = (n.state != r.state) ? '0 : r.timer + TW'(1);
    // Set beats a clear in the same cycle
    n.flags = (r.flags & ~clr) | set;
    any = n.glob_en && (|(n.flags & n.int_en & bfs_pkg::ALERT_CAPABLE));
    n.alert_n = !any;
    // ----------------------------------------------------------
    // Outputs decoded from the coming state
    n.drive.analog_enable = n.state inside {bfs_pkg::ST_PLSOFT, bfs_pkg::ST_BOOSTUP,
                                            bfs_pkg::ST_NORMAL, bfs_pkg::ST_DISCHARGE};
    n.drive.pl_fet_on = n.state inside {bfs_pkg::ST_PLSOFT, bfs_pkg::ST_BOOSTUP,
                                        bfs_pkg::ST_NORMAL};
    n.drive.vin_fault_en = n.drive.pl_fet_on;
    n.drive.boost_enable = !n.fset_lock &&
                           n.state inside {bfs_pkg::ST_BOOSTUP, bfs_pkg::ST_NORMAL};
    n.drive.boost_limit_reduced = n.state == bfs_pkg::ST_BOOSTUP;
    n.drive.boost_fault_en = n.state == bfs_pkg::ST_NORMAL;
    n.drive.boost_switch_halt = n.state == bfs_pkg::ST_NORMAL && s.fb_over_ovpl;
    n.drive.discharge_on = n.state == bfs_pkg::ST_DISCHARGE;
    n.drive.led_enable = (n.state == bfs_pkg::ST_NORMAL && n.bright) ? ~n.str_dis : '0;
    n.drive.use_internal_clock = !n.sync_seen;
    n.drive.spread_spectrum_on = n.fallback && s.sync_level;
    n.drive.six_phase_fallback = n.six_phase;
    n.drive.short_string_threshold = n.cfg_thr;
    // ----------------------------------------------------------
    // Bus: zero wait states, read data taken from post-write values
    n.hready = 1'b1;
    n.hresp = 1'b0;
    n.ap_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.ap_wr = hwrite;
      n.ap_addr = haddr[7:0];
      n.rdata = '0;
      if (!hwrite) begin
        case (haddr[7:0])
          bfs_pkg::OFS_STATUS: n.rdata[14:0] = n.flags;
          bfs_pkg::OFS_INT_EN: begin
            for (int i = 0; i < bfs_pkg::NFLAG; i++) begin
              n.rdata[2*i +: 2] = {2{n.int_en[i]}};
            end
            n.rdata[bfs_pkg::GLOB_POS] = n.glob_en;
          end
          bfs_pkg::OFS_CONTROL: n.rdata[1:0] = {n.bright, n.enable};
          bfs_pkg::OFS_STATE: n.rdata[17:0] = {n.fset_lock, n.fallback, n.six_phase,
                                               n.open_str, n.str_dis, r.state};
          bfs_pkg::OFS_CONFIG: n.rdata[1:0] = n.cfg_thr;
          default: n.rdata = '0;
        endcase
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= bfs_pkg::REGS_RST;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_cfg_clear;
    r.ap_wr && r.ap_addr == bfs_pkg::OFS_STATUS && hwdata[bfs_pkg::F_BAD_CFG] &&
    hwdata[bfs_pkg::CLR_POS + bfs_pkg::F_BAD_CFG] && r.state != bfs_pkg::ST_INIT;
  endsequence
  sequence s_rec_leave;
    r.state == bfs_pkg::ST_RECOVERY ##1 r.state == bfs_pkg::ST_STANDBY;
  endsequence

  a_status_clear: assert property (s_cfg_clear |=> !r.flags[bfs_pkg::F_BAD_CFG])
    else $error("status not cleared by paired write");
  a_recovery_time: assert property (s_rec_leave |->
    $past(r.timer) == TW'(RECOVERY_CYC - 1)) else $error("recovery left early");
  a_boost_oc_time: assert property ($rose(r.flags[bfs_pkg::F_BOOST_OC]) |->
    r.state == bfs_pkg::ST_RECOVERY && $past(r.uvp_cnt) == TW'(BOOST_UV_CYC - 1))
    else $error("boost overcurrent timing wrong");
  a_ovpl_stays: assert property ($rose(r.flags[bfs_pkg::F_OVP_LOW]) &&
    !$past(r.sync.fb_over_ovph) && $past(r.enable) && !$past(|r.sync.string_low) |->
    r.state == bfs_pkg::ST_NORMAL) else $error("low OVP left normal mode");
  a_alert_follows: assert property ($rose(r.flags[bfs_pkg::F_VIN_OV]) &&
    r.int_en[bfs_pkg::F_VIN_OV] && r.glob_en |-> !host_alert_n) else $error("alert missing");
  a_discharge_bound: assert property (r.state == bfs_pkg::ST_DISCHARGE |->
    r.timer < TW'(DISCHARGE_CYC)) else $error("discharge too long");
  a_latch_sticky: assert property (r.state == bfs_pkg::ST_LATCH |=>
    r.state == bfs_pkg::ST_LATCH) else $error("latched fault exited");
  a_led_gate: assert property (|r.drive.led_enable |->
    r.state == bfs_pkg::ST_NORMAL && r.bright) else $error("LED drive outside normal");
  a_config_lock: assert property (r.ap_wr && r.ap_addr == bfs_pkg::OFS_CONFIG &&
    r.state != bfs_pkg::ST_STANDBY |=> $stable(r.cfg_thr))
    else $error("config changed outside standby");
  a_fset_block: assert property (r.fset_lock |->
    !r.drive.boost_enable ##1 !r.drive.boost_enable)
    else $error("boost started with resistor fault");
endmodule : bfs_supervisor

/* File: src/bfs_pkg.sv */
// Shared constants and types of the backlight fault supervisor.
// Assumes a 25 MHz hclk and an AHB-Lite master with word transfers.
package bfs_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BOOST_UV_MS = 110;
  localparam int RECOVERY_MS = 200;
  localparam int DISCHARGE_MS = 400;
  localparam int SHORT_MS = 5;
  localparam int BOOST_UV_CYC = CLK_HZ / 1000 * BOOST_UV_MS;
  localparam int RECOVERY_CYC = CLK_HZ / 1000 * RECOVERY_MS;
  localparam int DISCHARGE_CYC = CLK_HZ / 1000 * DISCHARGE_MS;
  localparam int SHORT_CYC = CLK_HZ / 1000 * SHORT_MS;
  localparam int TMR_W = 24;
  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_INT_EN = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam int NFLAG = 15;
  localparam int NSTR = 6;
  localparam int CLR_POS = 16;
  localparam int GLOB_POS = 31;
  // Flag positions in the status register
  localparam int F_BOOST_OC = 0;
  localparam int F_OVP_LOW = 1;
  localparam int F_OVP_HIGH = 2;
  localparam int F_SYNC_LOST = 3;
  localparam int F_VIN_OV = 4;
  localparam int F_VIN_UV = 5;
  localparam int F_VIN_OC = 6;
  localparam int F_CORE_LOW = 7;
  localparam int F_OVERTEMP = 8;
  localparam int F_STRING = 9;
  localparam int F_OPEN = 10;
  localparam int F_BAD_CFG = 11;
  localparam int F_FREQ_RES = 12;
  localparam int F_PUMP_LVL = 13;
  localparam int F_PUMP_PARTS = 14;
  // Faults able to alert; open string alerts through the string flag
  localparam logic [14:0] ALERT_CAPABLE = 15'h1BF5;
  // Open-string detail holds until power cycle
  localparam logic [14:0] CLEARABLE = 15'h7BFF;
  localparam logic [14:0] INT_EN_RST = 15'h7FFF;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_INIT = 3'h0, ST_STANDBY = 3'h1, ST_PLSOFT = 3'h3, ST_BOOSTUP = 3'h2,
    ST_NORMAL = 3'h6, ST_DISCHARGE = 3'h7, ST_RECOVERY = 3'h5, ST_LATCH = 3'h4
  } bfs_state_t;

  typedef struct packed {
    logic init_done, pl_charged, fb_target_reached, fb_below_discharge;
    logic fb_under_uvp, fb_over_ovpl, fb_over_ovph, boost_at_max;
    logic vin_over, vin_under, vin_overcurrent, vdd_under, temp_over;
    logic sync_valid, sync_level, config_valid;
    logic boost_freq_resistor_bad, dimming_freq_resistor_bad;
    logic pump_level_bad, pump_parts_missing;
    logic [5:0] string_low, string_short;
  } bfs_sense_t;

  typedef struct packed {
    logic analog_enable, pl_fet_on, boost_enable, boost_limit_reduced;
    logic boost_switch_halt, discharge_on, vin_fault_en, boost_fault_en;
    logic use_internal_clock, spread_spectrum_on, six_phase_fallback;
    logic [5:0] led_enable;
    logic [1:0] short_string_threshold;
  } bfs_drive_t;

  typedef struct packed {
    bfs_state_t state;
    logic [TMR_W-1:0] timer, uvp_cnt, short_cnt;
    logic [14:0] flags, int_en;
    logic glob_en, enable, bright, fset_lock, sync_seen, fallback, six_phase;
    logic [1:0] cfg_thr;
    logic [5:0] str_dis, open_str;
    bfs_sense_t meta, sync;
    bfs_drive_t drive;
    logic alert_n, ap_wr, hready, hresp;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } bfs_regs_t;

  localparam bfs_regs_t REGS_RST = '{state: ST_INIT, int_en: INT_EN_RST,
    glob_en: 1'b1, alert_n: 1'b1, hready: 1'b1, default: '0};
endpackage : bfs_pkg

/* File: testbench/bfs_front_model.sv */
// Behavioural analog front end that sits across from the supervisor.
// Assumes the bench supplies fault levels on flt and chooses prompt or slow answers.
module bfs_front_model (
  // Clock and drive levels from the supervisor
  input wire logic hclk,
  input wire bfs_pkg::bfs_drive_t drive,
  // Bench controls
  input wire logic slow,
  input wire bfs_pkg::bfs_sense_t flt,
  // Levels sensed by the supervisor
  output bfs_pkg::bfs_sense_t sense
);
  timeunit 1ns;
  timeprecision 1ns;
  int pl_cnt = 0;
  int bst_cnt = 0;
  int dis_cnt = 0;
  int lim;
  // ==========================================================
  // Answer delays, each restarts when its drive level drops
  assign lim = slow ? 12 : 3;
  always @(posedge hclk) begin
    pl_cnt <= drive.pl_fet_on ? pl_cnt + 1 : 0;
    bst_cnt <= drive.boost_enable ? bst_cnt + 1 : 0;
    dis_cnt <= drive.discharge_on ? dis_cnt + 1 : 0;
  end
  // Bench faults pass through; the sequencing answers are added on top
  always_comb begin
    sense = flt;
    sense.init_done = 1'b1;
    sense.pl_charged = pl_cnt > lim;
    sense.fb_target_reached = bst_cnt > lim;
    // slow mode never discharges, so only the timer can end it
    sense.fb_below_discharge = !slow && dis_cnt > lim;
  end
endmodule : bfs_front_model

/* File: testbench/tb_backlight_fault_supervisor.sv */
// Self-checking bench for the backlight fault supervisor.
// Assumes the design with short timers and the front-end model beside it.
module tb_backlight_fault_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, host_alert_n, slow = 0;
  logic [31:0] hrdata, q, exp_fl = '0;
  bfs_pkg::bfs_sense_t sense, m0, flt = '0;
  bfs_pkg::bfs_drive_t drv;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'h8E3DFF23;
  logic [1:0] cfg;
  // ==========================================================
  // Clock, design and front end
  always #20 hclk = ~hclk;
  bfs_supervisor #(.BOOST_UV_CYC(20), .RECOVERY_CYC(30), .DISCHARGE_CYC(40),
    .SHORT_CYC(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense_i(sense),
    .drive_o(drv), .host_alert_n(host_alert_n));
  bfs_front_model fe (.hclk(hclk), .drive(drv), .slow(slow), .flt(flt), .sense(sense));
  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Waits on hready at each phase; only the watchdog ends a stuck wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("okay response", 1'b0, hresp);
  endtask : bus
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    do begin bus(1'b0, 8'h0C, 32'h0, q); n++; end while (q[2:0] !== s && n < 300);
    chk("state", s, q[2:0]);
  endtask : wait_st
  // Model of the clear rule: a flag drops only with its status and clear bits set
  task automatic clr(input logic [14:0] m, input logic both);
    bus(1'b1, 8'h00, {1'b0, both ? m : 15'h0, 1'b0, m}, q);
    if (both) exp_fl[14:0] = exp_fl[14:0] & ~(m & bfs_pkg::CLEARABLE);
    bus(1'b0, 8'h00, 32'h0, q);
    chk("status", exp_fl, q);
  endtask : clr
  // Raises a fault level, waits for the state it leads to, drops it and clears the flag
  task automatic trip(input bfs_pkg::bfs_sense_t m, input int f, input logic [2:0] s,
    input logic al);
    flt <= flt | m;
    exp_fl[f] = 1'b1;
    wait_st(s);
    repeat (4) @(posedge hclk);
    chk("fault alert", al, host_alert_n);
    flt <= flt & ~m;
    wait_st(3'h6);
    clr(15'(1 << f), 1'b1);
  endtask : trip
  task automatic fin(input string t);
    $display("test %s complete", t);
  endtask : fin
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge hclk);
    n_fail++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    flt.config_valid = 1'b1;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h04, 32'h0, q);
    chk("int_en reset", 32'hBFFFFFFF, q);
    bus(1'b0, 8'h20, 32'h0, q);
    chk("unmapped", 32'h0, q);
    wait_st(3'h1);
    chk("analog off", 1'b0, drv.analog_enable);
    cfg = 2'($random(seed));
    bus(1'b1, 8'h10, {30'h0, cfg}, q);
    @(posedge hclk);
    chk("threshold", cfg, drv.short_string_threshold);
    fin("standby");
    bus(1'b1, 8'h08, 32'h3, q);
    wait_st(3'h6);
    chk("input faults on", 1'b1, drv.vin_fault_en);
    chk("boost faults on", 1'b1, drv.boost_fault_en);
    chk("leds on", 6'h3F, drv.led_enable);
    // A configuration write outside standby must be ignored
    bus(1'b1, 8'h10, {30'h0, ~cfg}, q);
    @(posedge hclk);
    chk("threshold held", cfg, drv.short_string_threshold);
    fin("startup");
    flt.fb_over_ovpl <= 1'b1;
    exp_fl[bfs_pkg::F_OVP_LOW] = 1'b1;
    repeat (6) @(posedge hclk);
    chk("switch halt", 1'b1, drv.boost_switch_halt);
    chk("no alert", 1'b1, host_alert_n);
    wait_st(3'h6);
    flt.fb_over_ovpl <= 1'b0;
    repeat (6) @(posedge hclk);
    clr(15'h0002, 1'b0);
    clr(15'h0002, 1'b1);
    fin("low overvoltage");
    flt.vin_over <= 1'b1;
    exp_fl[bfs_pkg::F_VIN_OV] = 1'b1;
    wait_st(3'h1);
    chk("alert", 1'b0, host_alert_n);
    flt.vin_over <= 1'b0;
    wait_st(3'h6);
    clr(15'h0010, 1'b1);
    chk("alert released", 1'b1, host_alert_n);
    bus(1'b1, 8'h04, 32'h80000100, q);
    bus(1'b0, 8'h04, 32'h0, q);
    chk("int_en masked", 32'hBFFFFCFF, q);
    flt.vin_over <= 1'b1;
    exp_fl[bfs_pkg::F_VIN_OV] = 1'b1;
    wait_st(3'h1);
    chk("masked alert", 1'b1, host_alert_n);
    flt.vin_over <= 1'b0;
    bus(1'b1, 8'h04, 32'h00000300, q);
    repeat (4) @(posedge hclk);
    chk("global off", 1'b1, host_alert_n);
    bus(1'b1, 8'h04, 32'h80000000, q);
    repeat (4) @(posedge hclk);
    chk("global on", 1'b0, host_alert_n);
    wait_st(3'h6);
    clr(15'h0010, 1'b1);
    fin("input overvoltage");
    flt.vin_overcurrent <= 1'b1;
    exp_fl[bfs_pkg::F_VIN_OC] = 1'b1;
    wait_st(3'h5);
    flt.vin_overcurrent <= 1'b0;
    chk("fet off", 1'b0, drv.pl_fet_on);
    chk("alert", 1'b0, host_alert_n);
    wait_st(3'h6);
    clr(15'h0040, 1'b1);
    flt.fb_under_uvp <= 1'b1;
    exp_fl[bfs_pkg::F_BOOST_OC] = 1'b1;
    wait_st(3'h5);
    flt.fb_under_uvp <= 1'b0;
    wait_st(3'h6);
    clr(15'h0001, 1'b1);
    fin("recovery");
    m0 = '0;
    m0.vin_under = 1'b1;
    trip(m0, bfs_pkg::F_VIN_UV, 3'h1, 1'b0);
    m0 = '0;
    m0.vdd_under = 1'b1;
    trip(m0, bfs_pkg::F_CORE_LOW, 3'h1, 1'b0);
    m0 = '0;
    m0.temp_over = 1'b1;
    trip(m0, bfs_pkg::F_OVERTEMP, 3'h1, 1'b0);
    m0 = '0;
    m0.fb_over_ovph = 1'b1;
    trip(m0, bfs_pkg::F_OVP_HIGH, 3'h1, 1'b0);
    m0 = '0;
    m0.pump_level_bad = 1'b1;
    trip(m0, bfs_pkg::F_PUMP_LVL, 3'h6, 1'b1);
    fin("supply faults");
    slow <= 1'b1;
    bus(1'b1, 8'h08, 32'h2, q);
    wait_st(3'h7);
    chk("discharge", 1'b1, drv.discharge_on);
    wait_st(3'h1);
    slow <= 1'b0;
    flt.sync_valid <= 1'b1;
    flt.sync_level <= 1'b1;
    bus(1'b1, 8'h08, 32'h3, q);
    wait_st(3'h6);
    chk("sync clock", 1'b0, drv.use_internal_clock);
    fin("discharge");
    // External clock lost after enable: fallback with spread, no alert
    flt.sync_valid <= 1'b0;
    exp_fl[bfs_pkg::F_SYNC_LOST] = 1'b1;
    repeat (6) @(posedge hclk);
    chk("fallback clock", 1'b1, drv.use_internal_clock);
    chk("spread", 1'b1, drv.spread_spectrum_on);
    chk("sync no alert", 1'b1, host_alert_n);
    clr(15'h0008, 1'b1);
    // Two shorted strings beside working ones drop after the short time
    flt.string_short <= 6'h03;
    exp_fl[bfs_pkg::F_STRING] = 1'b1;
    repeat (20) @(posedge hclk);
    chk("shorted off", 6'h3C, drv.led_enable);
    chk("short alert", 1'b0, host_alert_n);
    flt.string_short <= 6'h00;
    clr(15'h0200, 1'b1);
    fin("sync and short");
    flt.boost_at_max <= 1'b1;
    flt.string_low <= 6'h3F;
    exp_fl[bfs_pkg::F_STRING] = 1'b1;
    exp_fl[bfs_pkg::F_OPEN] = 1'b1;
    wait_st(3'h4);
    chk("alert", 1'b0, host_alert_n);
    clr(15'h0400, 1'b1);
    clr(15'h0200, 1'b1);
    chk("alert released", 1'b1, host_alert_n);
    fin("latch");
    // Power cycle with an unknown string pattern and a bad frequency resistor
    m0 = '0;
    m0.boost_freq_resistor_bad = 1'b1;
    flt <= m0;
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    exp_fl = 32'h00001800;
    wait_st(3'h1);
    bus(1'b0, 8'h00, 32'h0, q);
    chk("status", exp_fl, q);
    chk("six phase", 1'b1, drv.six_phase_fallback);
    chk("config alert", 1'b0, host_alert_n);
    bus(1'b1, 8'h08, 32'h3, q);
    repeat (8) @(posedge hclk);
    bus(1'b0, 8'h0C, 32'h0, q);
    chk("resistor lock", 32'h00028001, q);
    chk("boost held off", 1'b0, drv.boost_enable);
    clr(15'h0800, 1'b1);
    clr(15'h1000, 1'b1);
    chk("alert released", 1'b1, host_alert_n);
    fin("power cycle");
    conclude();
  end
endmodule : tb_backlight_fault_supervisor
